// file: hw/tpl_line_ctrl.sv
// per-channel twisted-pair line configuration and squelch
// Operation
// - at 10 Mbps idle, no drive on line except link pulses
// - four-bit gain code: 0000 is 1.16, each step minus 0.02
// - edge code 11/10/01/00 gives -0.25/0/+0.25/+0.5 ns
// - edge adjust acts only at 100 Mbps, ignored at 10 Mbps
// - output disable: line outputs off, tx enable loopback off
// - shielded cable mode switches output current to its levels
// - at 10 Mbps the adaptive equalizer is bypassed and off
// - at 10 Mbps baseline wander correction is off
// - 10 Mbps squelch comparator feeds pulses; zero cross feeds data
// - 100 Mbps unsquelch on four alternating crossings in 10 us
// - while unsquelched use lowered threshold, input is valid
// - 100 Mbps loss of data after 10 us without alternations
// - 100 Mbps squelch state feeds link integrity
// - 10 Mbps unsquelch on three alternations within 50-250 ns
// - 10 Mbps end-of-frame idle marker returns to squelched
// - 10 Mbps squelch never feeds link integrity
// - 10 Mbps entering unsquelch marks packet start, asserts crs
// - receive level adjust lowers both squelch levels 4.5 dB
`timescale 1ns/1ps
module tpl_line_ctrl
  import tpl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // transmit side
  input wire logic tx_en,
  input wire logic tx_data,
  input wire logic lp_tx,
  output logic tp_tx_out,
  output logic tp_tx_oe,
  output logic [3:0] tx_gain_code,
  output logic [7:0] tx_gain_pct,
  output logic [1:0] tx_edge_rate_code,
  output logic tx_shield_cur,
  // receive analog controls
  output logic eq_en,
  output logic blw_en,
  output logic rx_thr_low,
  output logic rx_lvl_low,
  // receive comparators
  input wire logic sq_pos,
  input wire logic sq_neg,
  input wire logic zc_data,
  input wire logic end_of_frame_idle_marker,
  // receive results
  output logic cdr_data,
  output logic lp_det,
  output logic rev_pol_det,
  output logic rx_valid,
  output logic link_sq_ok,
  output logic sop,
  output logic crs,
  output logic los
);
  // ---------------------------------------------------------------
  // wishbone slave and configuration
  // ---------------------------------------------------------------
  logic [9:0] cfg_reg;
  logic los_seen_reg;
  logic ack_reg;
  logic [31:0] rd_data;
  logic req;
  logic wr_cfg;
  logic clr_los;
  logic spd100;

  tpl_sq_t sq_reg;
  tpl_sq_t sq_next;
  logic [WIN_W-1:0] quiet_reg;
  logic last_pol_reg;
  logic carrier;
  logic alt_un;
  logic hit100;
  logic hit10;
  logic los_ev;

  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_cfg = req && wb_we_i && wb_adr_i == REG_CFG;
  assign clr_los = req && wb_we_i && wb_adr_i == REG_STAT &&
                   wb_sel_i[0] && wb_dat_i[STAT_LOS_BIT];
  assign spd100 = cfg_reg[CFG_SPD_BIT];

  always_comb begin
    rd_data = 32'h0000_0000;
    if (wb_adr_i == REG_CFG) begin
      rd_data[9:0] = cfg_reg;
    end else if (wb_adr_i == REG_STAT) begin
      rd_data[STAT_UNSQ_BIT] = sq_reg;
      rd_data[STAT_CRS_BIT] = crs;
      rd_data[STAT_LOS_BIT] = los_seen_reg;
    end
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end
  assign wb_ack_o = ack_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= CFG_RST;
    end else if (wr_cfg) begin
      if (wb_sel_i[0]) begin
        cfg_reg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        cfg_reg[9:8] <= wb_dat_i[9:8];
      end
    end
  end

  // a new loss event beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      los_seen_reg <= 1'b0;
    end else if (los_ev) begin
      los_seen_reg <= 1'b1;
    end else if (clr_los) begin
      los_seen_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // transmit controls
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_gain_code <= GAIN_RST;
      tx_gain_pct <= GAIN_BASE_PCT - {3'h0, GAIN_RST, 1'b0};
      tx_edge_rate_code <= EDGE_NONE;
      tx_shield_cur <= 1'b0;
    end else begin
      tx_gain_code <= cfg_reg[CFG_GAIN_LSB +: 4];
      tx_gain_pct <= GAIN_BASE_PCT -
                     {3'h0, cfg_reg[CFG_GAIN_LSB +: 4], 1'b0};
      // analog side decodes 11/10/01/00 as -0.25/0/+0.25/+0.5 ns
      tx_edge_rate_code <= spd100 ?
                           cfg_reg[CFG_EDGE_LSB +: 2] :
                           EDGE_NONE;
      tx_shield_cur <= cfg_reg[CFG_SHLD_BIT];
    end
  end

  // line driver: 10 Mbps idle stays silent apart from link pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tp_tx_oe <= 1'b0;
      tp_tx_out <= 1'b0;
    end else begin
      tp_tx_oe <= !cfg_reg[CFG_DIS_BIT] &&
                  (spd100 || tx_en || lp_tx);
      tp_tx_out <= tx_en ? tx_data : lp_tx;
    end
  end

  // ---------------------------------------------------------------
  // receive analog controls
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eq_en <= 1'b1;
      blw_en <= 1'b1;
      rx_thr_low <= 1'b0;
      rx_lvl_low <= 1'b0;
    end else begin
      eq_en <= spd100;
      blw_en <= spd100;
      rx_thr_low <= sq_next;
      rx_lvl_low <= cfg_reg[CFG_RXADJ_BIT];
    end
  end

  // ---------------------------------------------------------------
  // squelch detectors
  // ---------------------------------------------------------------
  tpl_alt_win #(
    .WIN(SQ100_WIN_CYC),
    .MIN(0),
    .NEED(SQ100_NEED)
  ) u_win100 (
    .clk(clk),
    .rst_n(rst_n),
    .pos(sq_pos),
    .neg(sq_neg),
    .clr(!spd100 || sq_reg == TPL_UNSQUELCHED),
    .hit(hit100)
  );

  tpl_alt_win #(
    .WIN(SQ10_MAX_CYC),
    .MIN(SQ10_MIN_CYC),
    .NEED(SQ10_NEED)
  ) u_win10 (
    .clk(clk),
    .rst_n(rst_n),
    .pos(sq_pos),
    .neg(sq_neg),
    .clr(spd100 || sq_reg == TPL_UNSQUELCHED),
    .hit(hit10)
  );

  assign alt_un = (sq_pos || sq_neg) && (sq_pos != last_pol_reg);
  assign los_ev = spd100 && sq_reg == TPL_UNSQUELCHED && !alt_un &&
                  quiet_reg == WIN_W'(SQ100_WIN_CYC - 1);

  always_comb begin
    sq_next = sq_reg;
    case (sq_reg)
      TPL_SQUELCHED: begin
        if (spd100 ? hit100 : hit10) begin
          sq_next = TPL_UNSQUELCHED;
        end
      end
      TPL_UNSQUELCHED: begin
        if (los_ev) begin
          sq_next = TPL_SQUELCHED;
        end else if (!spd100 && end_of_frame_idle_marker) begin
          sq_next = TPL_SQUELCHED;
        end
      end
      default: sq_next = TPL_SQUELCHED;
    endcase
  end

  // quiet time counted on the channel clock, per channel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sq_reg <= TPL_SQUELCHED;
      quiet_reg <= '0;
      last_pol_reg <= 1'b0;
    end else begin
      sq_reg <= sq_next;
      if (sq_pos || sq_neg) begin
        last_pol_reg <= sq_pos;
      end
      if (sq_reg == TPL_SQUELCHED || alt_un || los_ev) begin
        quiet_reg <= '0;
      end else begin
        quiet_reg <= quiet_reg + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // receive results
  // ---------------------------------------------------------------
  assign carrier = sq_next == TPL_UNSQUELCHED;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cdr_data <= 1'b0;
      lp_det <= 1'b0;
      rev_pol_det <= 1'b0;
      rx_valid <= 1'b0;
      link_sq_ok <= 1'b0;
      sop <= 1'b0;
      crs <= 1'b0;
      los <= 1'b0;
    end else begin
      cdr_data <= zc_data;
      lp_det <= !spd100 && sq_pos && sq_reg == TPL_SQUELCHED;
      // a lone negative pulse outside a frame hints at swapped wires
      rev_pol_det <= !spd100 && sq_neg && !last_pol_reg &&
                     sq_reg == TPL_SQUELCHED;
      rx_valid <= carrier;
      link_sq_ok <= spd100 && carrier;
      sop <= !spd100 && sq_reg == TPL_SQUELCHED && carrier;
      crs <= carrier || (tx_en && !cfg_reg[CFG_DIS_BIT]);
      los <= los_ev;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_enter10;
    !spd100 && sq_reg == TPL_SQUELCHED && hit10;
  endsequence

  property p_idle10;
    !spd100 && !tx_en && !lp_tx |=> !tp_tx_oe;
  endproperty
  a_idle10: assert property (p_idle10)
    else $error("line driven while idle at 10 Mbps");

  property p_gain;
    tx_gain_code == 4'hF |-> tx_gain_pct == 8'h56;
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain code 1111 not at 0.86");

  property p_edge10;
    !spd100 [*2] |-> tx_edge_rate_code == EDGE_NONE;
  endproperty
  a_edge10: assert property (p_edge10)
    else $error("edge adjust applied at 10 Mbps");

  property p_dis;
    cfg_reg[CFG_DIS_BIT] && !carrier |=> !tp_tx_oe && !crs;
  endproperty
  a_dis: assert property (p_dis)
    else $error("disabled output still drives or loops back");

  property p_eq10;
    !spd100 |=> !eq_en && !blw_en;
  endproperty
  a_eq10: assert property (p_eq10)
    else $error("equalizer or wander correction on at 10 Mbps");

  property p_unsq100;
    spd100 && sq_reg == TPL_SQUELCHED && hit100 |=>
      sq_reg == TPL_UNSQUELCHED ##0 rx_thr_low;
  endproperty
  a_unsq100: assert property (p_unsq100)
    else $error("no unsquelch after four alternations");

  property p_thr;
    rx_thr_low == sq_reg && rx_valid == sq_reg;
  endproperty
  a_thr: assert property (p_thr)
    else $error("threshold or valid not tracking squelch state");

  property p_los;
    spd100 && sq_reg == TPL_UNSQUELCHED && !sq_pos && !sq_neg &&
      quiet_reg == WIN_W'(SQ100_WIN_CYC - 1) |=>
      sq_reg == TPL_SQUELCHED && los;
  endproperty
  a_los: assert property (p_los)
    else $error("no loss of data after quiet window");

  property p_eof;
    !spd100 && sq_reg == TPL_UNSQUELCHED && end_of_frame_idle_marker
      |=> sq_reg == TPL_SQUELCHED;
  endproperty
  a_eof: assert property (p_eof)
    else $error("end-of-frame idle did not squelch");

  property p_link10;
    !spd100 |=> !link_sq_ok;
  endproperty
  a_link10: assert property (p_link10)
    else $error("10 Mbps squelch reached link integrity");

  property p_sop;
    s_enter10 |=> sop && crs ##1 !sop;
  endproperty
  a_sop: assert property (p_sop)
    else $error("start of packet or carrier missing");
endmodule // tpl_line_ctrl

// file: hw/tpl_pkg.sv
// shared constants for the twisted-pair line control block
package tpl_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PS = 5000;
  localparam int SQ100_WIN_NS = 10000;
  localparam int SQ10_MIN_NS = 50;
  localparam int SQ10_MAX_NS = 250;
  // longest times round down, least times round up
  localparam int SQ100_WIN_CYC = (SQ100_WIN_NS * 1000) / CLK_PS;
  localparam int SQ10_MAX_CYC = (SQ10_MAX_NS * 1000) / CLK_PS;
  localparam int SQ10_MIN_CYC = (SQ10_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SQ100_NEED = 4;
  localparam int SQ10_NEED = 3;
  localparam int WIN_W = 12;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam int CFG_GAIN_LSB = 0;
  localparam int CFG_EDGE_LSB = 4;
  localparam int CFG_DIS_BIT = 6;
  localparam int CFG_SHLD_BIT = 7;
  localparam int CFG_RXADJ_BIT = 8;
  localparam int CFG_SPD_BIT = 9;
  localparam int STAT_UNSQ_BIT = 0;
  localparam int STAT_CRS_BIT = 1;
  localparam int STAT_LOS_BIT = 2;

  // ---------------------------------------------------------------
  // field codes and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] GAIN_RST = 4'h8;
  localparam logic [1:0] EDGE_NONE = 2'h2;
  localparam logic [7:0] GAIN_BASE_PCT = 8'h74;
  localparam logic [9:0] CFG_RST = 10'h228;

  typedef enum logic {
    TPL_SQUELCHED = 1'b0,
    TPL_UNSQUELCHED = 1'b1
  } tpl_sq_t;
endpackage

// file: hw/tpl_alt_win.sv
// alternating-polarity crossing counter within a time window
`timescale 1ns/1ps
module tpl_alt_win
  import tpl_pkg::*;
#(
  parameter int WIN = 50,
  parameter int MIN = 0,
  parameter int NEED = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // comparator pulses and control
  input wire logic pos,
  input wire logic neg,
  input wire logic clr,
  // detection
  output logic hit
);
  // parameters the counters cannot serve stop elaboration
  if (WIN < 2 || WIN >= (1 << WIN_W) || NEED < 2 || NEED > 7 ||
      MIN > WIN) begin : g_bad_param
    $error("tpl_alt_win: bad parameters");
  end

  logic armed_reg;
  logic last_reg;
  logic [2:0] cnt_reg;
  logic [WIN_W-1:0] t_reg;
  logic alt;
  logic [2:0] cnt_next;

  assign alt = armed_reg && (pos || neg) && (pos != last_reg);
  assign cnt_next = alt ? cnt_reg + 3'h1 : cnt_reg;
  // first and last crossing must span the least time as well
  assign hit = alt && (cnt_next == NEED[2:0]) &&
               (t_reg >= MIN[WIN_W-1:0]);

  // window starts at the first crossing, dies when it runs out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_reg <= 1'b0;
      last_reg <= 1'b0;
      cnt_reg <= 3'h0;
      t_reg <= '0;
    end else if (clr || hit ||
                 (armed_reg && t_reg == WIN_W'(WIN - 1))) begin
      armed_reg <= 1'b0;
      cnt_reg <= 3'h0;
      t_reg <= '0;
    end else if (!armed_reg) begin
      // count from one, so t_reg equals cycles since the first crossing
      if (pos || neg) begin
        armed_reg <= 1'b1;
        last_reg <= pos;
        cnt_reg <= 3'h1;
        t_reg <= WIN_W'(1);
      end
    end else begin
      t_reg <= t_reg + 1'b1;
      cnt_reg <= cnt_next;
      if (alt) begin
        last_reg <= pos;
      end
    end
  end
endmodule // tpl_alt_win

// file: verification/tpl_partner.sv
// remote link partner model seen through the receive comparators
`timescale 1ns/1ps
module tpl_partner (
  // clock
  input wire logic clk,
  // comparator view of the line
  output logic sq_pos,
  output logic sq_neg,
  output logic zc_data,
  output logic eof_mark
);
  initial begin
    sq_pos = 1'b0;
    sq_neg = 1'b0;
    zc_data = 1'b0;
    eof_mark = 1'b0;
  end

  // zero-cross data never sits still, so stale values cannot pass
  always @(posedge clk) begin
    zc_data <= ~zc_data;
  end

  // ------------------------------------------------------------
  // alternating crossings, first one positive, gap cycles apart
  // ------------------------------------------------------------
  task automatic burst(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      sq_pos <= ~i[0];
      sq_neg <= i[0];
      @(posedge clk);
      sq_pos <= 1'b0;
      sq_neg <= 1'b0;
      repeat (gap - 2) @(posedge clk);
    end
  endtask

  task automatic eof();
    @(posedge clk);
    eof_mark <= 1'b1;
    @(posedge clk);
    eof_mark <= 1'b0;
  endtask

  // single negative crossing, as swapped wires would show it
  task automatic lone_neg();
    @(posedge clk);
    sq_neg <= 1'b1;
    @(posedge clk);
    sq_neg <= 1'b0;
  endtask
endmodule // tpl_partner

// file: verification/tpl_line_ctrl_tb_top.sv
// self-checking testbench for the line control block
`timescale 1ns/1ps
module tpl_line_ctrl_tb_top
  import tpl_pkg::*;
;
  typedef struct packed {
    logic [9:0] cfg;
    logic [7:0] pct;
    logic [1:0] edge_c;
    logic [2:0] flg;
  } tpl_row_t;
  // flg is {shield, level adjust, speed100 analog enables}
  tpl_row_t rows [4] = '{
    '{10'h230, 8'h74, 2'h3, 3'h1},
    '{10'h21F, 8'h56, 2'h1, 3'h1},
    '{10'h088, 8'h64, 2'h2, 3'h4},
    '{10'h307, 8'h66, 2'h0, 3'h3}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic tx_en = 1'b0;
  logic tx_data = 1'b0;
  logic lp_tx = 1'b0;
  logic tp_tx_out, tp_tx_oe, tx_shield_cur, eq_en, blw_en, rx_thr_low;
  logic rx_lvl_low, cdr_data, lp_det, rev_pol_det, rx_valid, link_sq_ok;
  logic sop, crs, los, sq_pos, sq_neg, zc_data, eof_mark;
  logic [3:0] tx_gain_code;
  logic [7:0] tx_gain_pct;
  logic [1:0] tx_edge_rate_code;
  logic [31:0] rd;
  int miscompares = 0;
  int compares = 0;
  int sop_cnt = 0;
  int los_cnt = 0;
  int lp_cnt = 0;
  int rp_cnt = 0;

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (sop === 1'b1) sop_cnt++;
    if (los === 1'b1) los_cnt++;
    if (lp_det === 1'b1) lp_cnt++;
    if (rev_pol_det === 1'b1) rp_cnt++;
  end

  tpl_line_ctrl tpl_line_ctrl_i (.clk, .rst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .tx_en, .tx_data, .lp_tx, .tp_tx_out, .tp_tx_oe, .tx_gain_code,
    .tx_gain_pct, .tx_edge_rate_code, .tx_shield_cur, .eq_en, .blw_en,
    .rx_thr_low, .rx_lvl_low, .sq_pos, .sq_neg, .zc_data,
    .end_of_frame_idle_marker(eof_mark), .cdr_data, .lp_det,
    .rev_pol_det, .rx_valid, .link_sq_ok, .sop, .crs, .los);

  tpl_partner tpl_partner_i (.clk, .sq_pos, .sq_neg, .zc_data,
    .eof_mark);

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // classic cycle; ack is sampled at the edge, then released
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    chk({31'h0, wb_ack_o}, 32'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic results();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({eq_en, blw_en, tx_edge_rate_code, tx_gain_pct}, 32'hE64);
    wb(1'b0, REG_CFG, 32'h0, rd);
    chk(rd, {22'h0, CFG_RST});
    wb(1'b1, 4'h8, 32'h3FF, rd);
    wb(1'b0, 4'h8, 32'h0, rd);
    chk(rd, 32'h0);
    wb(1'b0, REG_STAT, 32'h0, rd);
    chk(rd, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      wb(1'b1, REG_CFG, {22'h0, rows[i].cfg}, rd);
      repeat (2) @(posedge clk);
      chk({28'h0, tx_gain_code}, {28'h0, rows[i].cfg[3:0]});
      chk({24'h0, tx_gain_pct}, {24'h0, rows[i].pct});
      chk({30'h0, tx_edge_rate_code}, {30'h0, rows[i].edge_c});
      chk({29'h0, tx_shield_cur, rx_lvl_low, eq_en}, {29'h0, rows[i].flg});
      chk({31'h0, blw_en}, {31'h0, rows[i].flg[0]});
      wb(1'b0, REG_CFG, 32'h0, rd);
      chk(rd, {22'h0, rows[i].cfg});
    end
    $display("config table test done");
    // disabled output at 10 Mbps while a frame is sent
    wb(1'b1, REG_CFG, 32'h048, rd);
    tx_en <= 1'b1;
    tx_data <= 1'b1;
    repeat (3) @(posedge clk);
    chk({tp_tx_oe, crs}, 32'h0);
    wb(1'b1, REG_CFG, 32'h008, rd);
    repeat (3) @(posedge clk);
    chk({tp_tx_oe, tp_tx_out, crs}, 32'h7);
    tx_en <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, tp_tx_oe}, 32'h0);
    lp_tx <= 1'b1;
    repeat (3) @(posedge clk);
    chk({tp_tx_oe, tp_tx_out}, 32'h3);
    lp_tx <= 1'b0;
    $display("transmit drive test done");
    // 10 Mbps squelch: too early, too late, then inside the window
    tpl_partner_i.burst(3, 4);
    repeat (60) @(posedge clk);
    chk({31'h0, rx_valid}, 32'h0);
    tpl_partner_i.burst(3, 25);
    repeat (60) @(posedge clk);
    chk({31'h0, rx_valid}, 32'h0);
    tpl_partner_i.burst(3, 5);
    repeat (3) @(posedge clk);
    chk(sop_cnt, 32'h1);
    chk({crs, rx_valid, rx_thr_low, link_sq_ok}, 32'hE);
    chk({31'h0, lp_cnt > 0}, 32'h1);
    tpl_partner_i.eof();
    repeat (3) @(posedge clk);
    chk({crs, rx_valid, rx_thr_low}, 32'h0);
    chk({31'h0, cdr_data}, {31'h0, ~zc_data});
    // last crossing was positive: only the second lone negative counts
    tpl_partner_i.lone_neg();
    tpl_partner_i.lone_neg();
    repeat (2) @(posedge clk);
    chk(rp_cnt, 32'h1);
    chk({31'h0, rx_valid}, 32'h0);
    $display("10 Mbps squelch test done");
    // 100 Mbps: three crossings fall short, four unsquelch
    wb(1'b1, REG_CFG, {22'h0, CFG_RST}, rd);
    tpl_partner_i.burst(3, 10);
    repeat (20) @(posedge clk);
    chk({31'h0, rx_valid}, 32'h0);
    repeat (2010) @(posedge clk);
    tpl_partner_i.burst(4, 10);
    repeat (3) @(posedge clk);
    chk({rx_valid, rx_thr_low, link_sq_ok, crs}, 32'hF);
    chk(sop_cnt, 32'h1);
    repeat (1980) @(posedge clk);
    chk({31'h0, rx_valid}, 32'h1);
    repeat (40) @(posedge clk);
    chk({rx_valid, link_sq_ok}, 32'h0);
    chk(los_cnt, 32'h1);
    wb(1'b0, REG_STAT, 32'h0, rd);
    chk(rd, 32'h4);
    wb(1'b1, REG_STAT, 32'h4, rd);
    wb(1'b0, REG_STAT, 32'h0, rd);
    chk(rd, 32'h0);
    $display("100 Mbps squelch test done");
    // reset in mid-run brings back the defaults
    wb(1'b1, REG_CFG, 32'h0C5, rd);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({eq_en, blw_en, tx_edge_rate_code, tx_gain_pct}, 32'hE64);
    chk({tx_shield_cur, tp_tx_oe, rx_valid}, 32'h0);
    wb(1'b0, REG_CFG, 32'h0, rd);
    chk(rd, {22'h0, CFG_RST});
    $display("mid-run reset test done");
    results();
  end
endmodule // tpl_line_ctrl_tb_top
